// ===== rtl/ptu_pkg.sv
// constants and carrier types for the timer channel pin and enable block
package ptu_pkg;

  localparam int CH_N = 3;

  // ---------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_IER_BASE = 8'h00;
  localparam logic [7:0] OFS_STS_BASE = 8'h0C;
  localparam logic [7:0] OFS_PINFN2   = 8'h18;
  localparam logic [7:0] OFS_GRA2     = 8'h1C;

  // ---------------------------------------------------------------------
  // enable and status bit positions
  // ---------------------------------------------------------------------
  localparam int BIT_ADC = 7;
  localparam int BIT_UDF = 5;
  localparam int BIT_OVF = 4;
  localparam int BIT_D   = 3;
  localparam int BIT_C   = 2;
  localparam int BIT_B   = 1;
  localparam int BIT_A   = 0;

  localparam logic [7:0] IER_RSV_ONE = 8'h40;
  localparam logic [7:0] IER_RST     = 8'h00;
  localparam logic [7:0] IER_WMASK [CH_N] = '{8'h9F, 8'hB3, 8'hB3};
  localparam logic [5:0] STS_MASK  [CH_N] = '{6'h1F, 6'h33, 6'h33};
  localparam logic [1:0] STS_TOP       = 2'h1;

  // ---------------------------------------------------------------------
  // pin function field of register A, channel 2
  // ---------------------------------------------------------------------
  localparam int PF_CAPTURE = 3;
  localparam int PF_INIT    = 2;
  localparam int PF_BOTH    = 1;
  localparam logic [3:0] PF_RST    = 4'h0;
  localparam logic [1:0] PF_OFF    = 2'h0;
  localparam logic [1:0] PF_LOW    = 2'h1;
  localparam logic [1:0] PF_HIGH   = 2'h2;
  localparam logic [1:0] PF_TOGGLE = 2'h3;
  localparam logic [1:0] CAP_RISE  = 2'h0;
  localparam logic [1:0] CAP_FALL  = 2'h1;

  localparam logic [15:0] GRA_RST  = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  // ---------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] count;      // channel_counter value
    logic        phaseMode;  // phase counting mode active
    logic [3:0]  matchIn;    // {D,C,B,A} match/capture events
  } ptu_chan_in_t;

  typedef struct packed {
    logic udf;
    logic ovf;
    logic matchD;
    logic matchC;
    logic matchB;
    logic matchA;
  } ptu_irq_t;

endpackage : ptu_pkg

// ===== rtl/ptu_ch_io.sv
// channel pin function, status flags and interrupt enables of the timer
//
// Contract
// RULE_01: field bit 3 low makes register A compare; bit 2 sets initial pin level.
// RULE_02: compare mode: low pair 00 disables pin output, 01 drives low on match.
// RULE_03: compare mode: low pair 10 drives pin A high on each match.
// RULE_04: compare mode: low pair 11 toggles pin A on each match.
// RULE_05: field bit 3 high makes register A capture channel 2 pin A.
// RULE_06: capture mode: low pair 00 captures on rising edges only.
// RULE_07: capture mode: low pair 01 captures on falling edges only.
// RULE_08: capture mode: bit 1 set captures on both edges.
// RULE_09: enable bit 7 gates converter start request from register A events.
// RULE_10: enable bit 6 always reads 1, writes ignored.
// RULE_11: bit 5 enables underflow interrupt in channels 1 and 2; reserved in 0.
// RULE_12: bit 4 gates overflow flag onto overflow interrupt request.
// RULE_13: bit 3 enables register D interrupt in channel 0 only; else reads 0.
// RULE_14: bit 2 enables register C interrupt in channel 0 only; else reads 0.
// RULE_15: bit 1 gates register B flag onto its interrupt in every channel.
// RULE_16: bit 0 gates register A flag onto its interrupt in every channel.
// RULE_17: three enable registers, one per channel, writable bits reset to 0.
// RULE_18: match flag sets on counter equal register, or on capture copy.
// RULE_19: overflow flag sets when counter wraps from maximum to zero.
// RULE_20: underflow flag sets when counter wraps zero to maximum, phase mode.
// RULE_21: flag clears only by writing 0 after reading it as 1; code also clears a flag set during that read's wait state.
// RULE_22: request is high while both flag and enable are high.
`timescale 1ns/100ps
module ptu_ch_io
  import ptu_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire ptu_chan_in_t chanIn   [CH_N],
  output ptu_irq_t          irqReq   [CH_N],
  output logic      [CH_N-1:0] adcStart,
  input  wire logic         pinAIn,
  output logic              pinAOut,
  output logic              pinAOe_n
);

  // ---------------------------------------------------------------------
  // apb slave: one wait state, so read data and error come from flops
  // ---------------------------------------------------------------------
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic [31:0] rdNext;
  logic        hit;
  logic        accessDone;
  logic [CH_N-1:0] wrIer;
  logic [CH_N-1:0] wrSts;
  logic [CH_N-1:0] rdSts;
  logic        wrPin;
  logic        wrGra;

  logic [7:0]  ienable_reg [CH_N];
  logic [5:0]  flags_reg   [CH_N];
  logic [5:0]  armed_reg   [CH_N];
  logic [15:0] cntPrev_reg [CH_N];
  logic [5:0]  irq_reg     [CH_N];
  logic [CH_N-1:0] adc_reg;
  logic [3:0]  pinFn_reg;
  logic [15:0] gra_reg;
  logic        pinLevel_reg;
  logic        pinOe_n_reg;
  logic        pinPrev_reg;
  logic        ch2MatchA;
  logic        capHit;
  logic        cmpHit;

  assign accessDone = psel & penable & pready_reg;

  always_comb begin
    rdNext = '0;
    hit    = 1'b0;
    wrIer  = '0;
    wrSts  = '0;
    rdSts  = '0;
    wrPin  = 1'b0;
    wrGra  = 1'b0;
    for (int c = 0; c < CH_N; c++) begin
      if (paddr == OFS_IER_BASE + 8'(4 * c)) begin
        hit      = 1'b1;
        rdNext   = {24'h0, ienable_reg[c] | IER_RSV_ONE}; // [RULE_10]
        wrIer[c] = accessDone & pwrite;
      end
      if (paddr == OFS_STS_BASE + 8'(4 * c)) begin
        hit      = 1'b1;
        rdNext   = {24'h0, STS_TOP, flags_reg[c]};
        wrSts[c] = accessDone & pwrite;
        rdSts[c] = accessDone & ~pwrite;
      end
    end
    if (paddr == OFS_PINFN2) begin
      hit    = 1'b1;
      rdNext = {28'h0, pinFn_reg};
      wrPin  = accessDone & pwrite;
    end
    if (paddr == OFS_GRA2) begin
      hit    = 1'b1;
      rdNext = {16'h0, gra_reg};
      wrGra  = accessDone & pwrite;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
      if (psel & penable & ~pready_reg) begin
        prdata_reg  <= pwrite ? 32'h0 : rdNext;
        pslverr_reg <= ~hit;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  assign pready  = pready_reg;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  // ---------------------------------------------------------------------
  // per channel flags, enables and requests
  // ---------------------------------------------------------------------
  for (genvar c = 0; c < CH_N; c++) begin : g_ch
    logic [5:0] evt;
    logic [5:0] clr;
    logic [5:0] flagNext;
    logic [7:0] enNext;
    logic       wrapUp;
    logic       wrapDown;

    assign wrapUp   = cntPrev_reg[c] == CNT_MAX && chanIn[c].count == CNT_ZERO;
    assign wrapDown = cntPrev_reg[c] == CNT_ZERO && chanIn[c].count == CNT_MAX;
    // match/capture of A on channel 2 is produced here, others come in
    assign evt = {wrapDown & chanIn[c].phaseMode, wrapUp,        // [RULE_19] [RULE_20]
                  chanIn[c].matchIn[3:1],
                  (c == 2) ? ch2MatchA : chanIn[c].matchIn[0]}   // [RULE_18]
                 & STS_MASK[c];
    // only bits set in the cycle a prior read completes may be cleared
    assign clr      = {6{wrSts[c]}} & armed_reg[c] & ~pwdata[5:0]; // [RULE_21]
    assign flagNext = (flags_reg[c] & ~clr) | evt;  // set beats clear
    assign enNext   = wrIer[c] ? (pwdata[7:0] & IER_WMASK[c])      // [RULE_13] [RULE_14]
                               : ienable_reg[c];

    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        ienable_reg[c] <= IER_RST;                                 // [RULE_17]
        flags_reg[c]   <= '0;
        armed_reg[c]   <= '0;
        cntPrev_reg[c] <= CNT_ZERO;
        irq_reg[c]     <= '0;
        adc_reg[c]     <= 1'b0;
      end else begin
        ienable_reg[c] <= enNext;
        flags_reg[c]   <= flagNext;
        cntPrev_reg[c] <= chanIn[c].count;
        if (rdSts[c])
          armed_reg[c] <= flags_reg[c];
        else if (wrSts[c])
          armed_reg[c] <= '0;
        // next-state terms so the request follows flag and enable at once
        irq_reg[c] <= flagNext & enNext[5:0];  // [RULE_11] [RULE_12] [RULE_15] [RULE_16] [RULE_22]
        adc_reg[c] <= evt[BIT_A] & ienable_reg[c][BIT_ADC];        // [RULE_09]
      end
    end

    assign irqReq[c]   = ptu_irq_t'(irq_reg[c]);
  end

  assign adcStart = adc_reg;

  // ---------------------------------------------------------------------
  // channel 2 register A: compare output or input capture
  // ---------------------------------------------------------------------
  logic capMode;
  logic pinRise;
  logic pinFall;

  assign capMode = pinFn_reg[PF_CAPTURE];                          // [RULE_05]
  assign pinRise = pinAIn & ~pinPrev_reg;
  assign pinFall = ~pinAIn & pinPrev_reg;
  assign capHit  = capMode & (pinFn_reg[PF_BOTH] ? (pinRise | pinFall)  // [RULE_08]
                  : pinFn_reg[0] ? pinFall                         // [RULE_07]
                  : pinRise);                                      // [RULE_06]
  // a held counter value matches only once, on the cycle it arrives
  assign cmpHit  = ~capMode & (chanIn[2].count != cntPrev_reg[2])
                   & (chanIn[2].count == gra_reg);
  assign ch2MatchA = capHit | cmpHit;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pinFn_reg <= PF_RST;
      gra_reg   <= GRA_RST;
    end else begin
      if (wrPin)
        pinFn_reg <= pwdata[3:0];
      if (capHit)
        gra_reg <= chanIn[2].count;  // capture wins over a software write
      else if (wrGra)
        gra_reg <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pinLevel_reg <= 1'b0;
      pinOe_n_reg  <= 1'b1;
      pinPrev_reg  <= 1'b0;
    end else begin
      pinPrev_reg <= pinAIn;
      if (wrPin) begin
        if (!pwdata[PF_CAPTURE]) begin
          pinLevel_reg <= pwdata[PF_INIT];                         // [RULE_01]
          pinOe_n_reg  <= (pwdata[1:0] == PF_OFF);                 // [RULE_02]
        end else begin
          pinOe_n_reg  <= 1'b1;
        end
      end else if (cmpHit) begin
        case (pinFn_reg[1:0])
          PF_LOW:    pinLevel_reg <= 1'b0;                         // [RULE_02]
          PF_HIGH:   pinLevel_reg <= 1'b1;                         // [RULE_03]
          PF_TOGGLE: pinLevel_reg <= ~pinLevel_reg;                // [RULE_04]
          default:   pinLevel_reg <= pinLevel_reg;
        endcase
      end
    end
  end

  assign pinAOut  = pinLevel_reg;
  assign pinAOe_n = pinOe_n_reg;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_stsWrUnarmed;
    wrSts[1] && flags_reg[1][BIT_OVF] && !armed_reg[1][BIT_OVF];
  endsequence

  sequence s_cmpToggle;
    cmpHit && !wrPin && pinFn_reg[1:0] == PF_TOGGLE;
  endsequence

  a_compare_off: assert property (!capMode && pinFn_reg[1:0] == PF_OFF  // [RULE_02]
    |-> pinAOe_n) else $error("pin driven while output disabled");
  a_compare_high: assert property (cmpHit && !wrPin                    // [RULE_03]
    && pinFn_reg[1:0] == PF_HIGH |=> pinAOut)
    else $error("pin not high after match");
  a_compare_toggle: assert property (s_cmpToggle                       // [RULE_04]
    |=> pinAOut != $past(pinAOut)) else $error("pin did not toggle");
  a_capture_nodrive: assert property (capMode && !wrPin                // [RULE_05]
    |=> pinAOe_n) else $error("pin driven in capture mode");
  a_capture_rise: assert property (capMode && pinFn_reg[1:0] == CAP_RISE // [RULE_06]
    && pinRise |=> gra_reg == $past(chanIn[2].count) && flags_reg[2][BIT_A])
    else $error("rising edge not captured");
  a_capture_fall: assert property (capMode && pinFn_reg[1:0] == CAP_FALL // [RULE_07]
    && pinRise |-> !capHit) else $error("rising edge captured in fall mode");
  a_adc_gate: assert property (adcStart[2]                             // [RULE_09]
    |-> $past(ienable_reg[2][BIT_ADC]) && $past(ch2MatchA))
    else $error("converter start without enable");
  // read data is loaded for the cycle pready is high and held until the next access, so look there
  a_rsv_one: assert property (rdSts == '0 && accessDone && !pwrite     // [RULE_10]
    && paddr == OFS_IER_BASE |-> prdata[6]) else $error("bit 6 read as 0");
  a_ch0_udf: assert property (!irqReq[0].udf && !flags_reg[0][BIT_UDF]) // [RULE_11]
    else $error("channel 0 underflow active");
  a_ch12_cd: assert property (ienable_reg[1][3:2] == 2'h0              // [RULE_13] [RULE_14]
    && ienable_reg[2][3:2] == 2'h0) else $error("reserved enable set");
  // software may drop the enable or clear the flag; only quiet cycles count
  a_ovf_wrap: assert property (                                        // [RULE_12]
    g_ch[1].wrapUp && ienable_reg[1][BIT_OVF] && !wrIer[1]
    ##1 !wrIer[1] && !wrSts[1] |-> irqReq[1].ovf [*2])
    else $error("overflow request missing");
  a_req_match: assert property ($rose(flags_reg[0][BIT_B])             // [RULE_15]
    |-> irqReq[0].matchB == ienable_reg[0][BIT_B])
    else $error("match B request wrong");
  a_clear_ignored: assert property (s_stsWrUnarmed                     // [RULE_21]
    |=> flags_reg[1][BIT_OVF]) else $error("unarmed clear took effect");

endmodule : ptu_ch_io

// ===== test/ptu_far_model.sv
// far-side model of channel 2 pin A
`timescale 1ns/100ps
module ptu_far_model (
  input  wire logic pinAOut,
  input  wire logic pinAOe_n,
  input  wire logic extLevel,
  output logic      pinAIn
);
  // an outside driver wins only while the block lets go of the pin
  assign pinAIn = pinAOe_n ? extLevel : pinAOut;
endmodule : ptu_far_model

// ===== test/testbench.sv
// self-checking bench for the timer channel pin and enable block
`timescale 1ns/100ps
module testbench
  import ptu_pkg::*;
;
  logic         clk_sys, reset, psel, penable, pwrite, pready, pslverr;
  logic         pinAIn, pinAOut, pinAOe_n, extLevel, perr, cap, rise;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rdat, wdat;
  logic [15:0]  a;
  logic [3:0]   code;
  logic [CH_N-1:0] adcStart;
  ptu_chan_in_t chanIn [CH_N];
  ptu_irq_t     irqReq [CH_N];
  int           bad_count, n_checks, i;

  ptu_ch_io u_ptu_ch_io (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .chanIn(chanIn),
    .irqReq(irqReq), .adcStart(adcStart), .pinAIn(pinAIn),
    .pinAOut(pinAOut), .pinAOe_n(pinAOe_n));
  ptu_far_model u_ptu_far_model (.pinAOut(pinAOut), .pinAOe_n(pinAOe_n),
    .extLevel(extLevel), .pinAIn(pinAIn));

  always #2.5 clk_sys = ~clk_sys;

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  task wrap_up;
    $display("TB: checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // held until pready is seen high; no fixed wait is assumed
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      bad_count++;
      $display("CHECK FAILED %0t bus timeout", $time);
      wrap_up();
    end
    rdat = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask : wr

  task rd(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(rdat, exp, "read");
  endtask : rd

  task step(input int c, input logic [15:0] cv, input logic l);
    @(posedge clk_sys);
    chanIn[c].count <= cv;
    extLevel        <= l;
    #1;
  endtask : step

  function automatic logic [31:0] exp_ier(int c, logic [7:0] w);
    return 32'((c == 0 ? (w & 8'h9F) : (w & 8'hB3)) | 8'h40);
  endfunction : exp_ier

  function automatic logic exp_pin(logic [3:0] cd);
    return cd[1:0] == 2'h1 ? 1'b0 : (cd[1:0] == 2'h2 ? 1'b1 : ~cd[2]);
  endfunction : exp_pin

  function automatic logic exp_cap(logic [3:0] cd, logic r);
    return cd[1] | (cd[0] ? ~r : r);
  endfunction : exp_cap

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0; reset = 1'b1; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; extLevel = 1'b0;
    bad_count = 0; n_checks = 0;
    for (i = 0; i < CH_N; i++) chanIn[i] = '0;
    void'($urandom(32'hD66E));
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    for (i = 0; i < CH_N; i++) rd(8'(4 * i), 32'h40);
    rd(OFS_PINFN2, 32'h0);
    for (i = 0; i < CH_N; i++) begin
      wdat = $urandom;
      wr(8'(4 * i), wdat);
      rd(8'(4 * i), exp_ier(i, wdat[7:0]));
    end
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(perr), 32'h1, "unmapped");
    $display("TB: register test done");
    wr(8'h04, 32'h10);
    step(1, 16'hFFFF, 1'b0);
    step(1, 16'h0000, 1'b0);
    step(1, 16'h0000, 1'b0);
    chk(32'(irqReq[1].ovf), 32'h1, "ovf irq");
    wr(8'h10, 32'h0);
    wr(8'h04, 32'h0);
    #1 chk(32'(irqReq[1].ovf), 32'h0, "ovf gate");
    rd(8'h10, 32'h50);
    wr(8'h10, 32'h0);
    rd(8'h10, 32'h40);
    chanIn[2].phaseMode <= 1'b1;
    wr(8'h08, 32'h20);
    step(2, 16'hFFFF, 1'b0);
    step(2, 16'hFFFF, 1'b0);
    chk(32'(irqReq[2].udf), 32'h1, "udf irq");
    chanIn[2].phaseMode <= 1'b0;
    wr(8'h00, 32'h8A);
    @(posedge clk_sys) chanIn[0].matchIn <= 4'hF;
    @(posedge clk_sys) chanIn[0].matchIn <= 4'h0;
    #1 chk(32'(irqReq[0]), 32'h0A, "ch0 irq");
    chk(32'(adcStart), 32'h1, "ch0 adc");
    $display("TB: flag test done");
    for (i = 0; i < 8; i++) begin
      code = 4'(i);
      a = 16'($urandom_range(65534, 1));
      wr(OFS_GRA2, 32'(a));
      wr(OFS_PINFN2, 32'(code));
      step(2, a - 16'h1, 1'b0);
      chk(32'({pinAOe_n, pinAOut}), 32'({code[1:0] == 2'h0, code[2]}),
          "pin init");
      step(2, a, 1'b0);
      step(2, a, 1'b0);
      if (code[1:0] == 2'h0) chk(32'(pinAOe_n), 32'h1, "pin off");
      else chk(32'(pinAOut), 32'(exp_pin(code)), "pin match");
    end
    $display("TB: compare test done");
    for (i = 0; i < 16; i++) begin
      code = 4'(8 + i / 2);
      rise = i[0];
      a = 16'($urandom);
      wr(OFS_PINFN2, 32'(code));
      wr(8'h08, 32'({code[2], 7'h01}));
      step(2, a, ~rise);
      step(2, a, ~rise);
      apb(1'b0, 8'h14, 32'h0);
      wr(8'h14, 32'h0);
      step(2, a + 16'h1, rise);
      step(2, a + 16'h1, rise);
      cap = exp_cap(code, rise);
      chk(32'(irqReq[2].matchA), 32'(cap), "capture");
      chk(32'(adcStart[2]), 32'(cap & code[2]), "adc");
      if (cap) rd(OFS_GRA2, 32'(16'(a + 16'h1)));
    end
    $display("TB: capture test done");
    wrap_up();
  end
endmodule : testbench
